// >>> mcp_master_clock_ctrl.sv
// Notes on behaviour
// - master clock is prescaled by one, two, four or eight before the PLL.
// - PLL multiplies prescaled input by integer feedback factor, nominal 294.912 MHz.
// - half-rate variants divide PLL output by two, 147.456 MHz nominal.
// - setting start bit resets the PLL and forces a relock.
// - lock status bit 0 set once the PLL is locked and stable.
// - lock is reached about 3.5 ms after enabling.
// - dedicated digital clock output pin driven under its own register.
// - oscillator expects a crystal at nominal system clock over 24.
`include "mcp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module mcp_master_clock_ctrl
	import mcp_pkg::*;
#(
	parameter int unsigned LOCK_CYC = `MCP_LOCK_CYC
)
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire mcp_reg_req_t  reg_req,
	output logic [15:0]        reg_rdata,
	output logic               reg_rvalid,
	input  wire logic          crystal_in_or_clock_pin,
	input  wire logic          half_rate_strap,
	output logic               crystal_drive_pin,
	output logic               buffered_clock_pin,
	output logic               pll_reset,
	output logic               pll_ref_tick,
	output logic [15:0]        pll_feedback_factor,
	output logic [1:0]         pll_prescale_sel,
	output logic               sysclk_post_div2,
	output logic               sysclk_source_sel,
	output logic               pll_locked
);

	localparam logic [10:0] REF_LOSS = 11'(`MCP_REF_LOSS_CYC - 1);

	// write decode used only for the sequencer's start and stop strobes; the
	// register file decodes the same offsets in its own case statement
	function automatic logic wr_hits(input mcp_reg_req_t req, input logic [15:0] addr);
		wr_hits = req.wr && (req.addr == addr);
	endfunction

	// pll core is held whenever the sequencer is idle or restarting
	function automatic logic pll_held(input mcp_pll_state_t st);
		pll_held = (st == ST_IDLE) || (st == ST_RESET);
	endfunction

	logic [15:0]    feedback_factor_reg_r;
	logic [15:0]    prescale_reg_r;
	logic [15:0]    src_sel_reg_r;
	logic [15:0]    start_reg_r;
	logic [15:0]    buffered_clock_pin_reg_r;
	mcp_pll_state_t state_r;
	mcp_pll_state_t state_nxt;
	logic           start_wr;
	logic           stop_wr;
	logic           acquiring;
	logic           ref_tick;
	logic           buffered_clock_pin_level;
	logic           lock_done;
	logic [10:0]    ref_gap_r;
	logic           ref_lost;
	logic           strap_taken_r;
	logic [15:0]    rdata_nxt;

	assign start_wr = wr_hits(reg_req, `MCP_ADDR_START) && reg_req.wdata[`MCP_START_BIT];

	// a start write with bit 0 clear parks the pll rather than being ignored
	assign stop_wr = wr_hits(reg_req, `MCP_ADDR_START) && !reg_req.wdata[`MCP_START_BIT];

	// writes to the status offset fall into the default arm and are dropped
	// configuration registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			feedback_factor_reg_r <= `MCP_FB_RST;
			prescale_reg_r        <= `MCP_PRESC_RST;
			src_sel_reg_r         <= `MCP_SRC_RST;
			start_reg_r           <= `MCP_START_RST;
			buffered_clock_pin_reg_r          <= `MCP_BUFFERED_CLOCK_PIN_RST;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				`MCP_ADDR_FB:     feedback_factor_reg_r <= reg_req.wdata;
				`MCP_ADDR_PRESC:  prescale_reg_r        <= reg_req.wdata;
				`MCP_ADDR_SRC:    src_sel_reg_r         <= reg_req.wdata;
				`MCP_ADDR_START:  start_reg_r           <= reg_req.wdata;
				`MCP_ADDR_BUFFERED_CLOCK_PIN: buffered_clock_pin_reg_r          <= reg_req.wdata;
				default:          ;
			endcase
		end
	end

	// settings take effect only at the start pulse, so a half-written
	// configuration never reaches a running PLL
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pll_feedback_factor <= `MCP_FB_RST;
			pll_prescale_sel    <= 2'h0;
			sysclk_source_sel   <= 1'b0;
		end
		else if (start_wr)
		begin
			pll_feedback_factor <= feedback_factor_reg_r;
			pll_prescale_sel    <= prescale_reg_r[`MCP_PRESC_H:`MCP_PRESC_L];
			sysclk_source_sel   <= src_sel_reg_r[`MCP_SRC_BIT];
		end
	end

	mcp_edge_div u_prescale (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.clk_level (crystal_in_or_clock_pin),
		.div_sel   (pll_prescale_sel),
		.tick      (ref_tick),
		.div_level ()
	);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pll_ref_tick <= 1'b0;
		else
			pll_ref_tick <= ref_tick && !pll_held(state_r);
	end

	// loss watchdog: slowest legal reference still ticks well inside this gap
	always_ff @(posedge clk_sys)
	begin
		if (rst || ref_tick || state_r == ST_RESET)
			ref_gap_r <= 11'h000;
		else if (!ref_lost)
			ref_gap_r <= ref_gap_r + 11'h001;
	end

	assign ref_lost = (ref_gap_r == REF_LOSS);

	// lock count runs only while acquiring; a lost reference starts it over
	assign acquiring = (state_r == ST_ACQ);

	mcp_lock_timer #(
		.LOCK_CYC (LOCK_CYC)
	) u_lock_timer (
		.clk_sys (clk_sys),
		.rst     (rst),
		.restart (!acquiring || ref_lost),
		.run     (acquiring),
		.done    (lock_done)
	);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (start_wr)
					state_nxt = ST_RESET;
			ST_RESET:
				state_nxt = ST_ACQ;
			ST_ACQ:
				if (lock_done)
					state_nxt = ST_LOCK;
			ST_LOCK:
				if (ref_lost)
					state_nxt = ST_ACQ;
			default:
				state_nxt = ST_IDLE;
		endcase
		if (start_wr)
			state_nxt = ST_RESET;
		else if (stop_wr)
			state_nxt = ST_IDLE;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pll_reset <= 1'b1;
		else
			pll_reset <= pll_held(state_nxt);
	end

	// flag follows the next state, so it drops on the edge that leaves lock
	// lock flag
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pll_locked <= 1'b0;
		else
			pll_locked <= (state_nxt == ST_LOCK);
	end

	// strap taken once, so a wobbling pin cannot change the rate mid-run
	// half-rate post divide
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			strap_taken_r    <= 1'b0;
			sysclk_post_div2 <= 1'b0;
		end
		else if (!strap_taken_r)
		begin
			strap_taken_r    <= 1'b1;
			sysclk_post_div2 <= half_rate_strap;
		end
	end

	// divide select is live, so the pin can be retuned without a relock
	// dedicated clock output
	mcp_edge_div u_buffered_clock_pin (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.clk_level (crystal_in_or_clock_pin),
		.div_sel   (buffered_clock_pin_reg_r[`MCP_BUFFERED_CLOCK_PIN_DIV_H:`MCP_BUFFERED_CLOCK_PIN_DIV_L]),
		.tick      (),
		.div_level (buffered_clock_pin_level)
	);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			buffered_clock_pin <= 1'b0;
		else
			buffered_clock_pin <= buffered_clock_pin_level & buffered_clock_pin_reg_r[`MCP_BUFFERED_CLOCK_PIN_EN];
	end

	// crystal drive stand-in
	// the real pin is an analog inverter; here only its sense is kept
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			crystal_drive_pin <= 1'b0;
		else
			crystal_drive_pin <= ~crystal_in_or_clock_pin;
	end

	// read data is captured on the strobe edge; a later status change waits
	// for the next read
	always_comb
	begin
		rdata_nxt = 16'h0000;
		case (reg_req.addr)
			`MCP_ADDR_FB:     rdata_nxt = feedback_factor_reg_r;
			`MCP_ADDR_PRESC:  rdata_nxt = prescale_reg_r;
			`MCP_ADDR_SRC:    rdata_nxt = src_sel_reg_r;
			`MCP_ADDR_START:  rdata_nxt = start_reg_r;
			`MCP_ADDR_LOCK:   rdata_nxt[`MCP_LOCK_BIT] = pll_locked;
			`MCP_ADDR_BUFFERED_CLOCK_PIN: rdata_nxt = buffered_clock_pin_reg_r;
			default:          rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			// answer one cycle after the strobe, with no wait states
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata <= rdata_nxt;
		end
	end

endmodule
`default_nettype wire

// >>> mcp_cfg.svh
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH

// register offsets
`define MCP_ADDR_FB      16'hF000
`define MCP_ADDR_PRESC   16'hF001
`define MCP_ADDR_SRC     16'hF002
`define MCP_ADDR_START   16'hF003
`define MCP_ADDR_LOCK    16'hF004
`define MCP_ADDR_BUFFERED_CLOCK_PIN  16'hF005

// reset values
`define MCP_FB_RST       16'h0060
`define MCP_PRESC_RST    16'h0000
`define MCP_SRC_RST      16'h0000
`define MCP_START_RST    16'h0000
`define MCP_BUFFERED_CLOCK_PIN_RST   16'h0000

// field positions
`define MCP_START_BIT    0
`define MCP_LOCK_BIT     0
`define MCP_SRC_BIT      0
`define MCP_BUFFERED_CLOCK_PIN_EN    0
`define MCP_BUFFERED_CLOCK_PIN_DIV_L 1
`define MCP_BUFFERED_CLOCK_PIN_DIV_H 2
`define MCP_PRESC_L      0
`define MCP_PRESC_H      1

// nominal figures
`define MCP_SYSCLK_KHZ   294912
`define MCP_HALF_KHZ     147456
`define MCP_XTAL_RATIO   24

// timing
`define MCP_CLK_PERIOD_NS 4
`define MCP_LOCK_TIME_US  3500
`define MCP_LOCK_CYC      ((`MCP_LOCK_TIME_US * 1000) / `MCP_CLK_PERIOD_NS)
`define MCP_REF_LOSS_NS   8192
`define MCP_REF_LOSS_CYC  (`MCP_REF_LOSS_NS / `MCP_CLK_PERIOD_NS)

`endif

// >>> mcp_pkg.sv
package mcp_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mcp_reg_req_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_RESET = 4'b0010,
		ST_ACQ   = 4'b0100,
		ST_LOCK  = 4'b1000
	} mcp_pll_state_t;

	// edge-count mask for a divide by 2**sel
	function automatic logic [2:0] mcp_div_mask(input logic [1:0] sel);
		case (sel)
			2'h0:    mcp_div_mask = 3'h0;
			2'h1:    mcp_div_mask = 3'h1;
			2'h2:    mcp_div_mask = 3'h3;
			default: mcp_div_mask = 3'h7;
		endcase
	endfunction

endpackage

// >>> mcp_edge_div.sv
`timescale 1ns/100ps
`default_nettype none
module mcp_edge_div
	import mcp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_level,
	input  wire logic [1:0] div_sel,
	output logic            tick,
	output logic            div_level
);

	logic       prev_r;
	logic [2:0] cnt_r;
	logic       rise;

	assign rise = clk_level & ~prev_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			prev_r <= 1'b0;
		else
			prev_r <= clk_level;
	end

	// free count of input edges; its bits are the binary divisions
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cnt_r <= 3'h0;
		else if (rise)
			cnt_r <= cnt_r + 3'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			tick <= 1'b0;
		else
			tick <= rise && ((cnt_r & mcp_div_mask(div_sel)) == mcp_div_mask(div_sel));
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			div_level <= 1'b0;
		else
		begin
			case (div_sel)
				2'h0:    div_level <= clk_level;
				2'h1:    div_level <= cnt_r[0];
				2'h2:    div_level <= cnt_r[1];
				default: div_level <= cnt_r[2];
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> mcp_lock_timer.sv
`timescale 1ns/100ps
`default_nettype none
module mcp_lock_timer
	import mcp_pkg::*;
#(
	parameter int unsigned LOCK_CYC = 875000
)
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic restart,
	input  wire logic run,
	output logic      done
);

	logic [19:0] cnt_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst || restart)
		begin
			cnt_r <= 20'h00000;
			done  <= 1'b0;
		end
		else if (run && !done)
		begin
			cnt_r <= cnt_r + 20'h00001;
			done  <= (cnt_r == 20'(LOCK_CYC - 1));
		end
	end

endmodule
`default_nettype wire

// >>> mcp_mclk_src.sv
`timescale 1ns/100ps
`default_nettype none
module mcp_mclk_src
#(
	parameter int HALF = 4
)
(
	input  wire logic clk_sys,
	input  wire logic run,
	output logic      mclk
);
	int cnt = 0;
	initial mclk = 1'b0;
	// steady master clock
	// stopping parks the pin low so the design sees a real loss, not a frozen level
	always @(posedge clk_sys)
	begin
		#1;
		if (!run)
		begin
			mclk = 1'b0;
			cnt = 0;
		end
		else if (++cnt >= HALF)
		begin
			mclk = ~mclk;
			cnt = 0;
		end
	end
endmodule
`default_nettype wire

// >>> mcp_master_clock_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mcp_master_clock_ctrl_asserts
	import mcp_pkg::*;
#(
	parameter int unsigned LOCK_CYC = 50
)
(
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire mcp_reg_req_t reg_req,
	input  wire logic [15:0]  reg_rdata,
	input  wire logic         reg_rvalid,
	input  wire logic         pll_reset,
	input  wire logic         pll_ref_tick,
	input  wire logic [15:0]  pll_feedback_factor,
	input  wire logic         sysclk_post_div2,
	input  wire logic         pll_locked
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic        start_wr;
	logic [31:0] since_r;
	assign start_wr = reg_req.wr && reg_req.addr == 16'hF003 && reg_req.wdata[0];
	always_ff @(posedge clk_sys)
		since_r <= (rst || start_wr) ? 32'h0 : since_r + 32'h1;
	sequence s_start;
		start_wr;
	endsequence
	sequence s_relock;
		pll_reset && !pll_locked ##1 (!pll_locked)[*6];
	endsequence
	AST_START_RESET: assert property (s_start |=> s_relock)
		else $error("start write did not restart the pll");
	AST_RVALID: assert property (reg_rvalid == $past(reg_req.rd))
		else $error("read valid not one cycle after read");
	AST_LOCK_READ: assert property (reg_req.rd && reg_req.addr == 16'hF004 |=> reg_rdata == {15'h0, $past(pll_locked)})
		else $error("lock status read wrong");
	AST_LOCK_TIME: assert property ($rose(pll_locked) |-> since_r >= LOCK_CYC)
		else $error("lock came too early");
	AST_LOCK_RUN: assert property (pll_locked |-> !pll_reset)
		else $error("lock flag while pll held in reset");
	AST_TICK_IDLE: assert property (pll_reset && $past(pll_reset) |-> !pll_ref_tick)
		else $error("reference tick while pll idle");
	AST_FB_HOLD: assert property (!$past(start_wr) |-> $stable(pll_feedback_factor))
		else $error("feedback factor changed without start");
	AST_STRAP_HOLD: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(sysclk_post_div2))
		else $error("half rate select changed in run");
	AST_UNMAPPED: assert property (reg_req.rd && (reg_req.addr < 16'hF000 || reg_req.addr > 16'hF005) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind mcp_master_clock_ctrl mcp_master_clock_ctrl_asserts #(.LOCK_CYC(LOCK_CYC)) mcp_master_clock_ctrl_asserts_i (
	.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .pll_reset(pll_reset), .pll_ref_tick(pll_ref_tick),
	.pll_feedback_factor(pll_feedback_factor), .sysclk_post_div2(sysclk_post_div2),
	.pll_locked(pll_locked));
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import mcp_pkg::*;
	localparam int unsigned LOCK = 50;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         strap = 1'b0;
	logic         run = 1'b1;
	mcp_reg_req_t req = '0;
	logic [15:0]  rdata, fb;
	logic [1:0]   psel;
	logic         rvalid, mclk, drv, clk_out, prst, tick, pdiv2, srcsel, locked;
	int           errors = 0;
	int           tests_run = 0;
	mcp_mclk_src #(.HALF(4)) mcp_mclk_src_i (.clk_sys(clk_sys), .run(run), .mclk(mclk));
	mcp_master_clock_ctrl #(.LOCK_CYC(LOCK)) mcp_master_clock_ctrl_i (
		.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.crystal_in_or_clock_pin(mclk), .half_rate_strap(strap), .crystal_drive_pin(drv),
		.buffered_clock_pin(clk_out), .pll_reset(prst), .pll_ref_tick(tick),
		.pll_feedback_factor(fb), .pll_prescale_sel(psel), .sysclk_post_div2(pdiv2),
		.sysclk_source_sel(srcsel), .pll_locked(locked));
	always #2 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one access then an idle cycle, so strobes never toggle twice in one step
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
		req.wr = w;
		req.rd = !w;
		req.addr = a;
		req.wdata = d;
		@(posedge clk_sys);
		#1;
		req = '0;
		q = rdata;
		if (!w)
			check("read valid", 16'(rvalid), 16'h0001);
		@(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e);
		logic [15:0] q;
		acc(1'b0, a, 16'h0000, q);
		check(n, q, e);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_lock(output int n);
		n = 0;
		while (locked !== 1'b1 && n < 5000)
		begin
			cyc(1);
			n++;
		end
		check("locked", 16'(locked), 16'h0001);
	endtask
	// partner clock is 8 cycles long, so 256 cycles hold 32 master rises
	task automatic edges(output int r, output int x, output int t);
		logic [1:0] v;
		r = 0;
		x = 0;
		t = 0;
		for (int i = 0; i < 256; i++)
		begin
			v = {clk_out, drv};
			cyc(1);
			r += int'(clk_out && !v[1]);
			x += int'(drv && !v[0]);
			t += int'(tick);
		end
	endtask
	task automatic close_out();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		close_out();
	end
	initial
	begin
		int n;
		int r;
		int x;
		int t;
		cyc(10);
		rst = 1'b0;
		rchk("feedback", 16'hF000, 16'h0060);
		check("full rate", 16'(pdiv2), 16'h0000);
		for (int a = 1; a < 7; a++)
			rchk("reset reg", 16'hF000 + 16'(a), 16'h0000);
		wr(16'hF005, 16'h0005);
		rchk("buffered_clock_pin reg", 16'hF005, 16'h0005);
		wr(16'hF004, 16'h0001);
		rchk("lock ro", 16'hF004, 16'h0000);
		wr(16'hF002, 16'h0001);
		// every prescale code, each with its own start and lock
		for (int c = 0; c < 4; c++)
		begin
			wr(16'hF000, 16'h0060 + 16'(c));
			wr(16'hF001, 16'(c));
			wr(16'hF003, 16'h0001);
			check("prescale", 16'(psel), 16'(c));
			check("factor", fb, 16'h0060 + 16'(c));
			check("source", 16'(srcsel), 16'h0001);
			check("lock clear", 16'(locked), 16'h0000);
			wait_lock(n);
			check("lock time", 16'(n >= LOCK && n <= LOCK + 3), 16'h0001);
			rchk("lock bit", 16'hF004, 16'h0001);
			edges(r, x, t);
			check("ref ticks", 16'(t), 16'(32 >> c));
		end
		wr(16'hF003, 16'h0001);
		check("relock clear", 16'(locked), 16'h0000);
		wait_lock(n);
		edges(r, x, t);
		check("buffered_clock_pin rises", 16'(r), 16'h0008);
		check("ref ticks div8", 16'(t), 16'h0004);
		check("xtal rises", 16'(x), 16'h0020);
		wr(16'hF005, 16'h0000);
		edges(r, x, t);
		check("buffered_clock_pin off", 16'(r), 16'h0000);
		run = 1'b0;
		cyc(2100);
		check("lock lost", 16'(locked), 16'h0000);
		run = 1'b1;
		wait_lock(n);
		check("relock", 16'(n <= LOCK + 100), 16'h0001);
		// bring-up predivider code, then a recommended divide-by-two pair
		wr(16'hF001, 16'h0002);
		wr(16'hF003, 16'h0001);
		check("prescale four", 16'(psel), 16'h0002);
		wr(16'hF000, 16'h0075);
		wr(16'hF001, 16'h0001);
		wr(16'hF003, 16'h0001);
		check("factor 117", fb, 16'h0075);
		check("prescale two", 16'(psel), 16'h0001);
		wr(16'hF003, 16'h0000);
		cyc(1);
		check("stopped", 16'({prst, locked}), 16'h0002);
		strap = 1'b1;
		rst = 1'b1;
		cyc(10);
		rst = 1'b0;
		cyc(2);
		check("half rate", 16'(pdiv2), 16'h0001);
		rchk("feedback again", 16'hF000, 16'h0060);
		close_out();
	end
endmodule
`default_nettype wire
